// [hw/bcl_pkg.sv]
// package: constants, types and register map of the commutation block
package bcl_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int TACH_WIDTH_NS = 113000;
	localparam int TACH_CYC_INT = (TACH_WIDTH_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int TACH_CNT_W = 12;
	localparam logic [TACH_CNT_W-1:0] TACH_CYC = TACH_CNT_W'(TACH_CYC_INT);
	localparam logic [TACH_CNT_W-1:0] TACH_ONE = 12'h001;
	localparam logic [TACH_CNT_W-1:0] TACH_ZERO = 12'h000;

	// register bus
	localparam int AXI_AW = 32;
	localparam int AXI_DW = 32;
	localparam logic [AXI_AW-1:0] CTRL_OFFS = 32'h0000_0000;
	localparam logic [AXI_AW-1:0] STATUS_OFFS = 32'h0000_0004;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// control field positions
	localparam int CTRL_COAST_BIT = 0;
	localparam int CTRL_BRAKE_BIT = 1;
	localparam int CTRL_FULL_BIT = 2;
	localparam int CTRL_W = 3;

	// status field positions
	localparam int ST_HALL_LSB = 0;
	localparam int ST_DIR_LAT_BIT = 3;
	localparam int ST_SR0_BIT = 4;
	localparam int ST_SR1_BIT = 5;
	localparam int ST_INHIBIT_BIT = 6;
	localparam int ST_TACH_BIT = 7;
	localparam int ST_ARMED_BIT = 8;
	localparam int ST_W = 9;

	// hall codes with no valid position
	localparam logic [2:0] HALL_ALL_LOW = 3'h0;
	localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

	// per-phase command
	typedef enum logic [1:0] {
		PH_OFF = 2'b00,
		PH_SRC = 2'b01,
		PH_SNK = 2'b10
	} bcl_phase_e;

	// gate drive for phases a, b, c (index 0 = a)
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} bcl_drive_s;

	localparam bcl_drive_s DRIVE_OFF = '{hi: 3'h0, lo: 3'h0};
	localparam bcl_drive_s DRIVE_BRAKE = '{hi: 3'h0, lo: 3'h7};

endpackage

// [hw/bcl_commutator.sv]
// file: commutation, direction protection and register slave
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - speed below threshold: direction latch follows direction request
// - speed above threshold: direction latch holds, request changes ignored
// - latched direction passes two shift stages; last stage steers decoder
// - latch or shift register input/output mismatch forces all phases off
// - shift register advances on oscillator tick, one to two ticks delay
// - hall code all low or all high turns every phase off
// - direction high decoding table for the six valid hall codes
// - direction low decoding table for the six valid hall codes
// - hall change gives fixed tach pulse; position latch frozen meanwhile
// - quadrant select low chops low sides, high chops all; no brake effect
// - brake turns high sides off and low sides on over decoding
// - coast turns all phases off, above commutation and braking
module bcl_commutator (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic clk_en_in,
	input wire logic pwm_tick_in,
	input wire logic pwm_on_in,
	input wire logic dir_in,
	input wire logic speed_above_in,
	input wire logic hall_1_in,
	input wire logic hall_2_in,
	input wire logic hall_3_in,
	input wire logic quad_full_in,
	input wire logic brake_in,
	input wire logic coast_in,
	output bcl_pkg::bcl_drive_s drive_out,
	output logic tach_out,
	input wire logic [bcl_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [bcl_pkg::AXI_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bcl_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [bcl_pkg::AXI_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	logic dir_lat;
	logic [1:0] dir_sr;
	logic armed;
	logic [2:0] hall_pos;
	logic [bcl_pkg::TACH_CNT_W-1:0] tach_cnt;
	logic [bcl_pkg::CTRL_W-1:0] ctrl;
	logic [bcl_pkg::AXI_AW-1:0] aw_addr;
	logic [bcl_pkg::AXI_DW-1:0] w_data;
	logic [3:0] w_strb;
	logic aw_got;
	logic w_got;
	logic [2:0] hall_now;
	logic inhibit;
	logic coast_eff;
	logic brake_eff;
	logic full_eff;
	bcl_pkg::bcl_phase_e ph [3];
	bcl_pkg::bcl_drive_s next_drive;
	logic [bcl_pkg::ST_W-1:0] status;

	////////////////////////////////////////////////////////////////////////
	// direction path

	assign hall_now = {hall_1_in, hall_2_in, hall_3_in};

	// direction latch, transparent only at low speed
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			dir_lat <= 1'b0;
		end else if (clk_en_in && !speed_above_in) begin
			dir_lat <= dir_in;
		end
	end

	// two stage shift register on the oscillator tick
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			dir_sr <= 2'h0;
		end else if (clk_en_in && pwm_tick_in) begin
			dir_sr <= {dir_sr[0], dir_lat};
		end
	end

	// armed once latch and both stages agree with the request
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			armed <= 1'b0;
		end else if (clk_en_in && dir_in == dir_lat &&
				dir_sr[0] == dir_lat && dir_sr[1] == dir_lat) begin
			armed <= 1'b1;
		end
	end

	// mismatch across latch or shift register blanks the phases
	assign inhibit = (dir_in != dir_lat) || (dir_lat != dir_sr[1]) ||
		!armed;

	////////////////////////////////////////////////////////////////////////
	// hall position latch and tach pulse

	// a hall change loads position and starts the fixed pulse
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			hall_pos <= bcl_pkg::HALL_ALL_LOW;
			tach_cnt <= bcl_pkg::TACH_ZERO;
			tach_out <= 1'b0;
		end else if (clk_en_in) begin
			if (tach_cnt != bcl_pkg::TACH_ZERO) begin
				tach_cnt <= tach_cnt - bcl_pkg::TACH_ONE;
				tach_out <= (tach_cnt != bcl_pkg::TACH_ONE);
			end else if (hall_now != hall_pos) begin
				hall_pos <= hall_now;
				tach_cnt <= bcl_pkg::TACH_CYC;
				tach_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// commutation decoder

	// phase a, b, c command from hall position and final stage
	always_comb begin
		ph = '{bcl_pkg::PH_OFF, bcl_pkg::PH_OFF, bcl_pkg::PH_OFF};
		case ({dir_sr[1], hall_pos})
			4'h9: ph = '{bcl_pkg::PH_OFF, bcl_pkg::PH_SNK, bcl_pkg::PH_SRC};
			4'hB: ph = '{bcl_pkg::PH_SNK, bcl_pkg::PH_OFF, bcl_pkg::PH_SRC};
			4'hA: ph = '{bcl_pkg::PH_SNK, bcl_pkg::PH_SRC, bcl_pkg::PH_OFF};
			4'hE: ph = '{bcl_pkg::PH_OFF, bcl_pkg::PH_SRC, bcl_pkg::PH_SNK};
			4'hC: ph = '{bcl_pkg::PH_SRC, bcl_pkg::PH_OFF, bcl_pkg::PH_SNK};
			4'hD: ph = '{bcl_pkg::PH_SRC, bcl_pkg::PH_SNK, bcl_pkg::PH_OFF};
			4'h5: ph = '{bcl_pkg::PH_SNK, bcl_pkg::PH_SRC, bcl_pkg::PH_OFF};
			4'h4: ph = '{bcl_pkg::PH_SNK, bcl_pkg::PH_OFF, bcl_pkg::PH_SRC};
			4'h6: ph = '{bcl_pkg::PH_OFF, bcl_pkg::PH_SNK, bcl_pkg::PH_SRC};
			4'h2: ph = '{bcl_pkg::PH_SRC, bcl_pkg::PH_SNK, bcl_pkg::PH_OFF};
			4'h3: ph = '{bcl_pkg::PH_SRC, bcl_pkg::PH_OFF, bcl_pkg::PH_SNK};
			4'h1: ph = '{bcl_pkg::PH_OFF, bcl_pkg::PH_SRC, bcl_pkg::PH_SNK};
			default: ph[0] = bcl_pkg::PH_OFF;
		endcase
	end

	assign coast_eff = coast_in || ctrl[bcl_pkg::CTRL_COAST_BIT];
	assign brake_eff = brake_in || ctrl[bcl_pkg::CTRL_BRAKE_BIT];
	assign full_eff = quad_full_in || ctrl[bcl_pkg::CTRL_FULL_BIT];

	// gate drive with chopping and overrides, coast first
	always_comb begin
		next_drive = bcl_pkg::DRIVE_OFF;
		for (int i = 0; i < 3; i++) begin
			next_drive.hi[i] = (ph[i] == bcl_pkg::PH_SRC) &&
				(pwm_on_in || !full_eff);
			next_drive.lo[i] = (ph[i] == bcl_pkg::PH_SNK) && pwm_on_in;
		end
		if (coast_eff || inhibit) begin
			next_drive = bcl_pkg::DRIVE_OFF;
		end else if (brake_eff) begin
			next_drive = bcl_pkg::DRIVE_BRAKE;
		end
	end

	// registered phase drive
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			drive_out <= bcl_pkg::DRIVE_OFF;
		end else if (clk_en_in) begin
			drive_out <= next_drive;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register slave

	assign status = {armed, tach_out, inhibit, dir_sr[1], dir_sr[0],
		dir_lat, hall_pos};

	// write address and data taken in either order, then answered
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
			ctrl <= bcl_pkg::CTRL_RST;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= bcl_pkg::RESP_OKAY;
		end else if (clk_en_in) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!aw_got && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_got && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (aw_got && w_got) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr == bcl_pkg::CTRL_OFFS) begin
					s_axi_bresp <= bcl_pkg::RESP_OKAY;
					if (w_strb[0]) begin
						ctrl <= w_data[bcl_pkg::CTRL_W-1:0];
					end
				end else if (aw_addr == bcl_pkg::STATUS_OFFS) begin
					s_axi_bresp <= bcl_pkg::RESP_OKAY;
				end else begin
					s_axi_bresp <= bcl_pkg::RESP_DECERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read answered the cycle after the address is taken
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= bcl_pkg::RESP_OKAY;
		end else if (clk_en_in) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= bcl_pkg::RESP_OKAY;
				if (s_axi_araddr == bcl_pkg::CTRL_OFFS) begin
					s_axi_rdata <= bcl_pkg::AXI_DW'(ctrl);
				end else if (s_axi_araddr == bcl_pkg::STATUS_OFFS) begin
					s_axi_rdata <= bcl_pkg::AXI_DW'(status);
				end else begin
					s_axi_rdata <= '0;
					s_axi_rresp <= bcl_pkg::RESP_DECERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_LATCH_FOLLOWS: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && !speed_above_in) |=> (dir_lat == $past(dir_in)))
		else $error("direction latch did not follow request");
	AST_LATCH_HOLDS: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		speed_above_in |=> $stable(dir_lat))
		else $error("direction latch changed at speed");
	AST_SHIFT_STEP: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && pwm_tick_in) |=>
		(dir_sr[0] == $past(dir_lat) && dir_sr[1] == $past(dir_sr[0])))
		else $error("shift register did not advance");
	AST_SHIFT_IDLE: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		!(clk_en_in && pwm_tick_in) |=> $stable(dir_sr))
		else $error("shift register moved without tick");
	AST_MISMATCH_OFF: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && (dir_in != dir_lat || dir_lat != dir_sr[1])) |=>
		(drive_out == bcl_pkg::DRIVE_OFF))
		else $error("phases driven during direction mismatch");
	AST_BAD_HALL_OFF: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && !brake_eff && (hall_pos == bcl_pkg::HALL_ALL_LOW ||
		hall_pos == bcl_pkg::HALL_ALL_HIGH)) |=>
		(drive_out == bcl_pkg::DRIVE_OFF))
		else $error("phases driven on illegal hall code");
	AST_ROW_FWD: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && !inhibit && !coast_eff && !brake_eff && pwm_on_in &&
		dir_sr[1] && hall_pos == 3'h1) |=>
		(drive_out.hi == 3'h4 && drive_out.lo == 3'h2))
		else $error("forward decode wrong for code 001");
	AST_ROW_REV: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && !inhibit && !coast_eff && !brake_eff && pwm_on_in &&
		!dir_sr[1] && hall_pos == 3'h5) |=>
		(drive_out.hi == 3'h2 && drive_out.lo == 3'h1))
		else $error("reverse decode wrong for code 101");
	AST_TACH_FREEZE: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		tach_out |=> $stable(hall_pos))
		else $error("hall position moved during tach pulse");
	AST_BRAKE: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && brake_eff && !coast_eff && !inhibit) |=>
		(drive_out == bcl_pkg::DRIVE_BRAKE))
		else $error("brake did not set low sides");
	AST_COAST: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && coast_eff) |=> (drive_out == bcl_pkg::DRIVE_OFF))
		else $error("phases driven during coast");
	AST_HALF_HIGH: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(clk_en_in && !full_eff && !pwm_on_in) |=> (drive_out.lo == 3'h0 ||
		drive_out == bcl_pkg::DRIVE_BRAKE))
		else $error("low side on while chop off");
	AST_RESET_OFF: assert property (@(posedge ref_clk_in)
		!armed |=> (drive_out == bcl_pkg::DRIVE_OFF))
		else $error("phases driven before arming");

endmodule

`default_nettype wire

// [verif/bcl_hall_model.sv]
// hall sensor model: three sensors 120 degrees apart, gray stepping
`timescale 1ns/100ps
`default_nettype none
module bcl_hall_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic step_in,
	input wire logic [1:0] bad_in,
	output logic [2:0] hall_out
);
	// sectors 001 011 010 110 100 101, no inversion needed at 120 degrees
	localparam logic [17:0] SEQ = 18'h2CC99;
	logic [2:0] pos;
	////////////////////////////////////////
	// sector advances one per step; faulty states only on command
	always_ff @(posedge clk_in) begin
		if (rst_in || (step_in && pos == 3'h5)) begin
			pos <= 3'h0;
		end else if (step_in) begin
			pos <= pos + 3'h1;
		end
		hall_out <= bad_in[0] ? 3'h0 : bad_in[1] ? 3'h7 : SEQ[3 * pos +: 3];
	end
endmodule
`default_nettype wire

// [verif/tb_bldc_commutation_direction_logic.sv]
// testbench: commutation block driven by a hall sensor model
`timescale 1ns/100ps
`default_nettype none
module tb_bldc_commutation_direction_logic;
	logic clk = 1'h0, rst = 1'h1, tick = 1'h0, tick_on = 1'h0, pwm = 1'h1;
	logic dir = 1'h1, spd = 1'h0, full = 1'h0, brk = 1'h0, cst = 1'h0;
	logic step = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, tach, awready, wready, bvalid;
	logic arready, rvalid;
	logic en = 1'h1;
	logic [3:0] strb = 4'hF;
	logic [1:0] bad = 2'h0, bresp, rresp, rr;
	logic [2:0] hall, lat = 3'h0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
	bcl_pkg::bcl_drive_s drv;
	int fail_count = 0, num_checks = 0, cyc = 0, tcnt = 0;
	bcl_hall_model hall_u (.clk_in(clk), .rst_in(rst), .step_in(step),
		.bad_in(bad), .hall_out(hall));
	bcl_commutator dut_u (.ref_clk_in(clk), .rst_in(rst), .clk_en_in(en),
		.pwm_tick_in(tick), .pwm_on_in(pwm), .dir_in(dir),
		.speed_above_in(spd), .hall_1_in(hall[2]), .hall_2_in(hall[1]),
		.hall_3_in(hall[0]), .quad_full_in(full), .brake_in(brk),
		.coast_in(cst), .drive_out(drv), .tach_out(tach),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	////////////////////////////////////////
	// clock
	initial forever #25 clk = ~clk;
	// tick every 40 cycles, expected position latch, hang limit (~46000 used)
	always @(posedge clk) begin
		tcnt <= (tcnt == 39) ? 0 : tcnt + 1;
		tick <= tick_on && tcnt == 0;
		if (rst) lat <= 3'h0;
		else if (tach !== 1'h1) lat <= hall;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fail_count++;
			give_verdict();
		end
	end
	// expected gate drive from latched position and controls
	function automatic bcl_pkg::bcl_drive_s exp_drv(input logic d);
		logic [5:0] t;
		logic [2:0] s, k;
		case (lat)
			3'h1: t = 6'h22;
			3'h3: t = 6'h21;
			3'h2: t = 6'h11;
			3'h6: t = 6'h14;
			3'h4: t = 6'h0C;
			3'h5: t = 6'h0A;
			default: t = 6'h00;
		endcase
		{s, k} = d ? t : {t[2:0], t[5:3]};
		if (cst) return bcl_pkg::DRIVE_OFF;
		if (brk) return bcl_pkg::DRIVE_BRAKE;
		return '{hi: s & {3{pwm | ~full}}, lo: k & {3{pwm}}};
	endfunction
	task automatic chk_drive(input bcl_pkg::bcl_drive_s e);
		num_checks++;
		if (drv !== e) begin
			fail_count++;
			$display("ERROR drive_out expected %h seen %h", e, drv);
		end
	endtask
	task automatic chk_word(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	////////////////////////////////////////
	// bus master cycles
	task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
		logic ad, wd;
		ad = 1'h0;
		wd = 1'h0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(ad && wd)) begin
			@(negedge clk);
			ad = ad | (awvalid & awready);
			wd = wd | (wvalid & wready);
			@(posedge clk);
			if (ad) awvalid <= 1'h0;
			if (wd) wvalid <= 1'h0;
		end
		do @(negedge clk); while (bvalid !== 1'h1);
		chk_word("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
		bready <= 1'h0;
	endtask
	task automatic axi_rd(input logic [31:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge clk); while (arready !== 1'h1);
		@(posedge clk);
		arvalid <= 1'h0;
		do @(negedge clk); while (rvalid !== 1'h1);
		rd = rdata;
		rr = rresp;
		@(posedge clk);
		rready <= 1'h0;
	endtask
	// hall move: steps sectors (or fault code), check drive and tach width
	task automatic move(input logic [1:0] b, input int steps, input logic pend);
		int n;
		n = 0;
		@(posedge clk);
		bad <= b;
		step <= steps != 0;
		full <= 1'($urandom);
		pwm <= 1'($urandom);
		repeat (steps > 1 ? steps : 1) @(posedge clk);
		step <= 1'h0;
		while (tach !== 1'h1 && n < 9) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (tach === 1'h1 && n < 3000) begin
			@(negedge clk);
			n++;
			if (n == 3) chk_drive(exp_drv(dir));
		end
		if (!pend) chk_word("tach width", bcl_pkg::TACH_CYC, n);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(48403));
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		wt(30);
		chk_drive(bcl_pkg::DRIVE_OFF);
		axi_rd(bcl_pkg::CTRL_OFFS);
		chk_word("ctrl reset", 32'h0, rd);
		@(posedge clk);
		tick_on <= 1'h1;
		wt(120);
		chk_drive(exp_drv(1'h1));
		wt(2300);
		$display("test reset done");
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			dir <= !i[0];
			wt(120);
			repeat (6) move(2'h0, 1, 1'h0);
			move(2'h0, 2, 1'h0);
			move(2'h0, 0, 1'h1);
			$display("test decode done");
		end
		@(posedge clk);
		dir <= 1'h1;
		pwm <= 1'h1;
		wt(3);
		chk_drive(bcl_pkg::DRIVE_OFF);
		axi_rd(bcl_pkg::STATUS_OFFS);
		chk_word("dir latch", 32'h1, 32'(rd[bcl_pkg::ST_DIR_LAT_BIT]));
		wt(120);
		chk_drive(exp_drv(1'h1));
		@(posedge clk);
		spd <= 1'h1;
		dir <= 1'h0;
		wt(120);
		chk_drive(bcl_pkg::DRIVE_OFF);
		axi_rd(bcl_pkg::STATUS_OFFS);
		chk_word("dir latch", 32'h1, 32'(rd[bcl_pkg::ST_DIR_LAT_BIT]));
		@(posedge clk);
		spd <= 1'h0;
		wt(120);
		chk_drive(exp_drv(1'h0));
		$display("test direction done");
		move(2'h1, 0, 1'h0);
		move(2'h2, 0, 1'h0);
		move(2'h0, 0, 1'h0);
		$display("test illegal hall done");
		@(posedge clk);
		pwm <= 1'h1;
		@(posedge clk);
		en <= 1'h0;
		dir <= 1'h1;
		wt(100);
		chk_drive(exp_drv(1'h0));
		@(posedge clk);
		en <= 1'h1;
		dir <= 1'h0;
		wt(3);
		chk_drive(exp_drv(1'h0));
		$display("test clock enable done");
		@(posedge clk);
		brk <= 1'h1;
		full <= 1'h1;
		pwm <= 1'h0;
		wt(3);
		chk_drive(exp_drv(1'h0));
		@(posedge clk);
		cst <= 1'h1;
		wt(3);
		chk_drive(exp_drv(1'h0));
		@(posedge clk);
		brk <= 1'h0;
		cst <= 1'h0;
		axi_wr(bcl_pkg::CTRL_OFFS, 32'h2, bcl_pkg::RESP_OKAY);
		wt(2);
		chk_drive(bcl_pkg::DRIVE_BRAKE);
		axi_wr(bcl_pkg::CTRL_OFFS, 32'h1, bcl_pkg::RESP_OKAY);
		wt(2);
		chk_drive(bcl_pkg::DRIVE_OFF);
		axi_rd(bcl_pkg::CTRL_OFFS);
		chk_word("ctrl", 32'h1, rd);
		axi_wr(bcl_pkg::CTRL_OFFS, 32'h0, bcl_pkg::RESP_OKAY);
		@(posedge clk);
		strb <= 4'hE;
		axi_wr(bcl_pkg::CTRL_OFFS, 32'h1, bcl_pkg::RESP_OKAY);
		axi_rd(bcl_pkg::CTRL_OFFS);
		chk_word("ctrl strobe", 32'h0, rd);
		strb <= 4'hF;
		axi_wr(bcl_pkg::STATUS_OFFS, 32'h0, bcl_pkg::RESP_OKAY);
		axi_wr(32'h10, 32'h7, bcl_pkg::RESP_DECERR);
		axi_rd(32'h10);
		chk_word("unmapped read", {bcl_pkg::RESP_DECERR, 30'h0}, {rr, rd[29:0]});
		$display("test brake coast bus done");
		give_verdict();
	end
endmodule
`default_nettype wire
